/* logic/tld_pkg.sv */
// shared constants and types for the three-state longline driver array
// assumes a single 20 MHz clock domain with a synchronous, active-high reset
//
// Function
// - control high floats the driver, control low passes the data input.
// - every logic cell owns two drivers, to the longline above and below.
// - each driver runs in one of four modes: buffer, wired-AND, wired OR-AND, off.
// - wired-AND ties control to data: low input pulls low, high releases.
// - wired OR-AND releases if either input is high, pulls low if both low.
// - with every open-drain driver released, the pull-up makes the line high.
// - an undriven line keeps its level; any driver or pull-up overrides that.
// - several drivers on one line form a multiplexer chosen by their controls.
// - each left and right edge pad block has one more driver of the same reach.
// - perimeter lines wire-AND pad signals and internal longlines as edge decoders.
package tld_pkg;

  // ==========================================================================
  // driver modes
  localparam int TLD_MODE_W = 2;

  typedef enum logic [TLD_MODE_W-1:0] {
    TLD_MODE_STD   = 2'b00,  // plain three-state buffer
    TLD_MODE_WAND  = 2'b01,  // open-drain, control tied to data
    TLD_MODE_ORAND = 2'b10,  // open-drain two-input OR
    TLD_MODE_OFF   = 2'b11   // unused driver, always released
  } tld_mode_t;

  // ==========================================================================
  // array geometry
  localparam int TLD_ROWS_DEF = 2;   // rows of logic cells
  localparam int TLD_COLS_DEF = 4;   // logic cells per row
  localparam int TLD_CELL_DRV = 2;   // drivers per logic cell
  localparam int TLD_EDGE_DRV = 2;   // edge pad drivers per row (left, right)
  localparam int TLD_EDGE_SIDES = 2; // perimeter decoder lines (left, right)

  // ==========================================================================
  // reset values
  localparam logic TLD_LINE_RST = 1'b1;  // keeper starts the lines high
  localparam logic TLD_CLASH_RST = 1'b0;
  localparam logic TLD_DEC_RST = 1'b0;
  localparam logic TLD_SYNC_RST = 1'b0;

endpackage

/* logic/tld_driver_cell.sv */
// one three-state / open-drain longline driver cell
// assumes the caller resolves the shared line from pull_low and drive_high
`timescale 1ns/1ps

module tld_driver_cell (
  // configuration
  input wire tld_pkg::tld_mode_t i_mode,
  // driver inputs
  input wire logic i_data,
  input wire logic i_tri,
  input wire logic i_or_input_b,
  // drive towards the line
  output logic o_pull_low,
  output logic o_drive_high
);
  import tld_pkg::*;

  // ==========================================================================
  // mode decode; i_data doubles as or_input_a in the OR-AND mode
  always_comb begin
    o_pull_low = 1'b0;
    o_drive_high = 1'b0;
    case (i_mode)
      TLD_MODE_STD: begin
        o_pull_low = !i_tri && !i_data;
        o_drive_high = !i_tri && i_data;
      end
      TLD_MODE_WAND: begin
        // control follows data, so the cell never drives high
        o_pull_low = !i_data;
      end
      TLD_MODE_ORAND: begin
        o_pull_low = !(i_data || i_or_input_b);
      end
      default: begin
        o_pull_low = 1'b0; // unused driver stays off the line
      end
    endcase
  end

endmodule

/* logic/tld_longline_array.sv */
// row-organised array of longline drivers with line resolution and edge decoders
// assumes driver controls come from logic on i_clk; pad inputs come from pins
`timescale 1ns/1ps

module tld_longline_array #(
  parameter int NR = tld_pkg::TLD_ROWS_DEF,
  parameter int NC = tld_pkg::TLD_COLS_DEF,
  parameter int NL = NR + 1,
  parameter int NDR = NC * tld_pkg::TLD_CELL_DRV + tld_pkg::TLD_EDGE_DRV,
  parameter int ND = NR * NDR,
  parameter int NP = NR * tld_pkg::TLD_EDGE_DRV
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // per-driver configuration and inputs
  input wire logic [ND*tld_pkg::TLD_MODE_W-1:0] i_drv_mode,
  input wire logic [ND-1:0] i_drv_data,
  input wire logic [ND-1:0] i_drv_tri,
  input wire logic [ND-1:0] i_drv_or_b,
  // per-line pull-up enables
  input wire logic [NL-1:0] i_pullup_en,
  // pad inputs and edge decoder selects
  input wire logic [NP-1:0] i_pad_in,
  input wire logic [tld_pkg::TLD_EDGE_SIDES*NP-1:0] i_dec_pad_sel,
  input wire logic [tld_pkg::TLD_EDGE_SIDES*NL-1:0] i_dec_line_sel,
  // resolved lines and status
  output logic [NL-1:0] o_line,
  output logic [NL-1:0] o_contention,
  output logic [tld_pkg::TLD_EDGE_SIDES-1:0] o_edge_dec
);
  import tld_pkg::*;

  // ==========================================================================
  // driver placement
  // within a row: cell c owns driver 2c (line above) and 2c+1 (line below),
  // then the left and right edge pad drivers, both on the line above
  function automatic int drv_target(input int d);
    int row;
    int j;
    row = d / NDR;
    j = d % NDR;
    if (j < NC * TLD_CELL_DRV) begin
      drv_target = row + (j % TLD_CELL_DRV);
    end else begin
      drv_target = row;
    end
  endfunction

  function automatic logic [ND-1:0] line_mask(input int l);
    logic [ND-1:0] m;
    m = '0;
    for (int d = 0; d < ND; d++) begin
      if (drv_target(d) == l) begin
        m[d] = 1'b1;
      end
    end
    line_mask = m;
  endfunction

  // ==========================================================================
  // state
  typedef struct packed {
    logic [NL-1:0] line;
    logic [NL-1:0] clash;
    logic [TLD_EDGE_SIDES-1:0] dec;
    logic [NP-1:0] sync1;
    logic [NP-1:0] sync2;
    logic [NP-1:0] sync3;
    logic [NP-1:0] pad;
  } tld_state_t;

  tld_state_t state_reg;
  tld_state_t state_next;

  logic [ND-1:0] drv_low;
  logic [ND-1:0] drv_high;
  logic [NL-1:0] low_any;
  logic [NL-1:0] high_any;
  tld_mode_t drv_mode [ND];

  // ==========================================================================
  // driver cells, one per mode slice
  for (genvar d = 0; d < ND; d++) begin : g_drv
    assign drv_mode[d] = tld_mode_t'(i_drv_mode[d*TLD_MODE_W +: TLD_MODE_W]);

    tld_driver_cell tld_driver_cell_inst (
      .i_mode(drv_mode[d]),
      .i_data(i_drv_data[d]),
      .i_tri(i_drv_tri[d]),
      .i_or_input_b(i_drv_or_b[d]),
      .o_pull_low(drv_low[d]),
      .o_drive_high(drv_high[d])
    );
  end

  // ==========================================================================
  // gather the drivers that reach each line
  for (genvar l = 0; l < NL; l++) begin : g_gather
    localparam logic [ND-1:0] MASK = line_mask(l);
    assign low_any[l] = |(drv_low & MASK);
    assign high_any[l] = |(drv_high & MASK);
  end

  // ==========================================================================
  // next-state: line resolution, clash flags, pad filter, edge decoders
  // lines are registered, so the keeper is simply the held register value;
  // a clash resolves low, as the low-side pull is the stronger on real wires
  always_comb begin
    state_next = state_reg;
    for (int l = 0; l < NL; l++) begin
      if (low_any[l]) begin
        state_next.line[l] = 1'b0;
      end else if (high_any[l]) begin
        state_next.line[l] = 1'b1;
      end else if (i_pullup_en[l]) begin
        state_next.line[l] = 1'b1;
      end else begin
        state_next.line[l] = state_reg.line[l];
      end
    end
    // two standard drivers at odds show up here, not on the line
    state_next.clash = low_any & high_any;
    // pins pass three flops; a change counts once stages two and three agree
    state_next.sync1 = i_pad_in;
    state_next.sync2 = state_reg.sync1;
    state_next.sync3 = state_reg.sync2;
    for (int p = 0; p < NP; p++) begin
      if (state_reg.sync2[p] == state_reg.sync3[p]) begin
        state_next.pad[p] = state_reg.sync3[p];
      end
    end
    // perimeter wired-AND over the selected pads and longlines
    for (int s = 0; s < TLD_EDGE_SIDES; s++) begin
      state_next.dec[s] = &(~i_dec_pad_sel[s*NP +: NP] | state_reg.pad) &
                          &(~i_dec_line_sel[s*NL +: NL] | state_reg.line);
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg.line <= {NL{TLD_LINE_RST}};
      state_reg.clash <= {NL{TLD_CLASH_RST}};
      state_reg.dec <= {TLD_EDGE_SIDES{TLD_DEC_RST}};
      state_reg.sync1 <= {NP{TLD_SYNC_RST}};
      state_reg.sync2 <= {NP{TLD_SYNC_RST}};
      state_reg.sync3 <= {NP{TLD_SYNC_RST}};
      state_reg.pad <= {NP{TLD_SYNC_RST}};
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // outputs, straight from the state register
  assign o_line = state_reg.line;
  assign o_contention = state_reg.clash;
  assign o_edge_dec = state_reg.dec;

  // ==========================================================================
  // checks on each driver cell
  for (genvar d = 0; d < ND; d++) begin : g_drv_chk
    tristate_float_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (drv_mode[d] == TLD_MODE_STD && i_drv_tri[d]) |-> (!drv_low[d] && !drv_high[d]))
      else $error("floated buffer still drives");

    std_pass_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (drv_mode[d] == TLD_MODE_STD && !i_drv_tri[d]) |->
        (drv_high[d] == i_drv_data[d] && drv_low[d] == !i_drv_data[d]))
      else $error("enabled buffer does not pass data");

    wand_drive_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (drv_mode[d] == TLD_MODE_WAND) |-> (!drv_high[d] && drv_low[d] == !i_drv_data[d]))
      else $error("wired-and cell drives wrongly");

    orand_drive_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (drv_mode[d] == TLD_MODE_ORAND) |->
        (!drv_high[d] && drv_low[d] == !(i_drv_data[d] || i_drv_or_b[d])))
      else $error("or-and cell drives wrongly");

    off_release_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (drv_mode[d] == TLD_MODE_OFF) |-> (!drv_low[d] && !drv_high[d]))
      else $error("unused driver touches the line");
  end

  // ==========================================================================
  // checks on line resolution
  for (genvar l = 0; l < NL; l++) begin : g_line_chk
    low_wins_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      low_any[l] |=> !state_reg.line[l])
      else $error("line not pulled low");

    mux_select_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (high_any[l] && !low_any[l]) |=> state_reg.line[l])
      else $error("selected high driver lost");

    pullup_high_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (!low_any[l] && !high_any[l] && i_pullup_en[l]) |=> state_reg.line[l])
      else $error("pull-up failed to raise line");

    keeper_hold_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (!low_any[l] && !high_any[l] && !i_pullup_en[l]) |=>
        (state_reg.line[l] == $past(state_reg.line[l])))
      else $error("keeper lost line level");

    clash_flag_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (low_any[l] && high_any[l]) |=> state_reg.clash[l] ##1 (state_reg.clash[l] == $past(high_any[l] && low_any[l])))
      else $error("contention not flagged");
  end

  // ==========================================================================
  // checks on edge drivers, pad filter and decoders
  for (genvar r = 0; r < NR; r++) begin : g_edge_chk
    edge_driver_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (drv_low[r*NDR + NC*TLD_CELL_DRV] || drv_low[r*NDR + NC*TLD_CELL_DRV + 1]) |=> !state_reg.line[r])
      else $error("edge driver did not reach its line");
  end

  for (genvar p = 0; p < NP; p++) begin : g_pad_chk
    sequence pad_high_run;
      i_pad_in[p] [*3];
    endsequence

    pad_filter_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      pad_high_run |-> ##2 state_reg.pad[p])
      else $error("steady pad not accepted");
  end

  for (genvar s = 0; s < TLD_EDGE_SIDES; s++) begin : g_dec_chk
    edge_decode_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      1'b1 |=> (state_reg.dec[s] == $past(&(~i_dec_pad_sel[s*NP +: NP] | state_reg.pad) &
                                          &(~i_dec_line_sel[s*NL +: NL] | state_reg.line))))
      else $error("edge decoder value wrong");

    // independent of the decode expression: one low selected line forces the decoder low
    dec_line_low_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (|(i_dec_line_sel[s*NL +: NL] & ~state_reg.line)) |=> !state_reg.dec[s])
      else $error("selected low line did not pull decoder low");
  end

endmodule

/* sim/tld_line_user.sv */
// far-side user logic model: hands the shared line to one standard-mode driver
// assumes grant inputs change just after a rising edge of the array clock
`timescale 1ns/1ps

module tld_line_user #(
  parameter int ND = 20
) (
  // normal grant
  input wire logic i_grant_en,
  input wire logic [4:0] i_grant_idx,
  // deliberate second talker, only when a test asks for a clash
  input wire logic i_clash_en,
  input wire logic [4:0] i_clash_idx,
  // high-impedance controls towards the drivers
  output logic [ND-1:0] o_drv_tri
);
  // ==========================================================================
  // one-hot enable
  // all other drivers float, so only i_clash_en can give a multiplexed line two talkers
  always_comb begin
    o_drv_tri = '1;
    if (i_grant_en) begin
      o_drv_tri[i_grant_idx] = 1'b0;
    end
    if (i_clash_en) begin
      o_drv_tri[i_clash_idx] = 1'b0;
    end
  end
endmodule

/* sim/tld_longline_array_tb.sv */
// self-checking bench for the longline driver array
// assumes the array package is compiled first; the far side is tld_line_user
`timescale 1ns/1ps

module tld_longline_array_tb;
  import tld_pkg::*;
  localparam int ND = 20;
  logic i_clk, i_rst, grant_en, clash_en;
  logic [4:0] grant_idx, clash_idx;
  logic [2*ND-1:0] drv_mode;
  logic [ND-1:0] drv_data, drv_tri, drv_or_b;
  logic [2:0] pullup_en, line, contention;
  logic [3:0] pad_in;
  logic [7:0] dec_pad_sel;
  logic [5:0] dec_line_sel;
  logic [1:0] edge_dec;
  int fail_count, checks_done, cycles;
  int mux_idx [6] = '{0, 2, 4, 6, 8, 9};

  // ==========================================================================
  // instances
  tld_longline_array #(.NR(2), .NC(4)) tld_longline_array_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_drv_mode(drv_mode), .i_drv_data(drv_data),
    .i_drv_tri(drv_tri), .i_drv_or_b(drv_or_b), .i_pullup_en(pullup_en),
    .i_pad_in(pad_in), .i_dec_pad_sel(dec_pad_sel), .i_dec_line_sel(dec_line_sel),
    .o_line(line), .o_contention(contention), .o_edge_dec(edge_dec));
  tld_line_user #(.ND(ND)) tld_line_user_inst (
    .i_grant_en(grant_en), .i_grant_idx(grant_idx), .i_clash_en(clash_en),
    .i_clash_idx(clash_idx), .o_drv_tri(drv_tri));

  // ==========================================================================
  // helpers
  // inputs always move 1 ns after the edge so no race with the registers
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, seen);
      fail_count++;
    end
  endtask

  task automatic set_mode(input int d, input tld_mode_t m);
    drv_mode[2*d+:2] = m;
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // scenarios
  task automatic test_buffer();
    set_mode(0, TLD_MODE_STD);
    grant_en = 1'b1;
    grant_idx = 5'h00;
    for (int v = 0; v < 3; v++) begin
      drv_data[0] = v[0];
      tick(1);
      check("buffer line0", {7'h00, line[0]}, {7'h00, v[0]});
    end
    drv_data[0] = 1'b0;
    tick(1);
    grant_en = 1'b0;
    tick(2);
    check("floating line0 kept", {7'h00, line[0]}, 8'h00);
    pullup_en[0] = 1'b1;
    tick(1);
    check("pullup overrides keeper", {7'h00, line[0]}, 8'h01);
    $display("test buffer done");
  endtask

  // drivers 1 and 10 both reach line 1, from the cell above and below it
  task automatic test_wand();
    pullup_en[1] = 1'b1;
    set_mode(1, TLD_MODE_WAND);
    set_mode(10, TLD_MODE_WAND);
    for (int k = 0; k < 4; k++) begin
      drv_data[1] = k[0];
      drv_data[10] = k[1];
      tick(1);
      check("wired and line1", {7'h00, line[1]}, {7'h00, k[0] & k[1]});
    end
    set_mode(1, TLD_MODE_OFF);
    set_mode(10, TLD_MODE_OFF);
    $display("test wired and done");
  endtask

  task automatic test_orand();
    pullup_en[0] = 1'b1;
    set_mode(0, TLD_MODE_ORAND);
    for (int k = 0; k < 4; k++) begin
      drv_data[0] = k[0];
      drv_or_b[0] = k[1];
      tick(1);
      check("or-and line0", {7'h00, line[0]}, {7'h00, k != 0});
    end
    drv_or_b[0] = 1'b0;
    drv_data[0] = 1'b0;
    set_mode(0, TLD_MODE_OFF);
    tick(1);
    check("off mode released", {7'h00, line[0]}, 8'h01);
    $display("test or-and done");
  endtask

  // the even (line-above) cell drivers and both edge drivers of row 0 share line 0
  task automatic test_mux();
    pullup_en[0] = 1'b0;
    foreach (mux_idx[i]) set_mode(mux_idx[i], TLD_MODE_STD);
    grant_en = 1'b1;
    foreach (mux_idx[i]) begin
      for (int v = 0; v < 2; v++) begin
        drv_data = {ND{~v[0]}};
        drv_data[mux_idx[i]] = v[0];
        grant_idx = 5'(mux_idx[i]);
        tick(1);
        check("mux line0", {7'h00, line[0]}, {7'h00, v[0]});
        check("no clash", {7'h00, contention[0]}, 8'h00);
      end
    end
    drv_data = '0;
    drv_data[0] = 1'b1;
    grant_idx = 5'h00;
    clash_en = 1'b1;
    clash_idx = 5'h02;
    tick(1);
    check("clash line0", {7'h00, line[0]}, 8'h00);
    check("clash flagged", {7'h00, contention[0]}, 8'h01);
    clash_en = 1'b0;
    grant_en = 1'b0;
    drv_mode = '1;
    tick(1);
    check("clash cleared", {7'h00, contention[0]}, 8'h00);
    $display("test mux done");
  endtask

  task automatic test_decoder();
    dec_pad_sel = 8'h21;
    pad_in = 4'h3;
    tick(1);
    pad_in = 4'h0;
    tick(6);
    check("glitch filtered", {6'h00, edge_dec}, 8'h00);
    pad_in = 4'h3;
    tick(4);
    check("decoder not yet", {6'h00, edge_dec}, 8'h00);
    tick(1);
    check("pads decoded", {6'h00, edge_dec}, 8'h03);
    pullup_en[0] = 1'b1;
    dec_line_sel = 6'h01;
    tick(2);
    check("line high joins", {6'h00, edge_dec}, 8'h03);
    set_mode(0, TLD_MODE_STD);
    drv_data[0] = 1'b0;
    grant_idx = 5'h00;
    grant_en = 1'b1;
    tick(2);
    check("line low decodes", {6'h00, edge_dec}, 8'h02);
    $display("test decoder done");
  endtask

  // row 1: cell 0 below reaches line 2, the left edge driver reaches line 1
  task automatic test_row1();
    drv_mode = '1;
    pullup_en = 3'h0;
    drv_data = '0;
    set_mode(11, TLD_MODE_STD);
    set_mode(18, TLD_MODE_STD);
    grant_en = 1'b1;
    grant_idx = 5'h0b;
    tick(1);
    check("row1 cell below line2", {7'h00, line[2]}, 8'h00);
    grant_idx = 5'h12;
    tick(1);
    check("row1 edge line1", {7'h00, line[1]}, 8'h00);
    check("line2 kept", {7'h00, line[2]}, 8'h00);
    check("row1 no clash", {5'h00, contention}, 8'h00);
    $display("test row1 done");
  endtask

  // ==========================================================================
  // clock, timeout and main sequence
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      conclude();
    end
  end

  initial begin
    {fail_count, checks_done, cycles} = '0;
    {i_rst, grant_en, clash_en} = 3'h4;
    {grant_idx, clash_idx} = '0;
    drv_mode = '1;
    {drv_data, drv_or_b} = '0;
    {pullup_en, pad_in, dec_pad_sel, dec_line_sel} = '0;
    tick(2);
    i_rst = 1'b0;
    check("reset lines", {5'h00, line}, 8'h07);
    check("reset flags", {3'h0, contention, edge_dec}, 8'h00);
    test_buffer();
    test_wand();
    test_orand();
    test_mux();
    test_decoder();
    test_row1();
    conclude();
  end
endmodule
